// >>> grr_defines.svh
// Constants for the gamma reference serial and refresh control block
`ifndef GRR_DEFINES_SVH
`define GRR_DEFINES_SVH

// Serial word geometry
`define GRR_WORD_BITS 16
`define GRR_WORD_MSB 15
`define GRR_CNT_W 5
`define GRR_CNT_FULL 5'h10
`define GRR_CNT_FIRST 5'h01
`define GRR_CNT_ONE 5'h01

// Channel set
`define GRR_NUM_CH 10
`define GRR_CH_W 4
`define GRR_LAST_CH 4'h9
`define GRR_FIRST_CH 4'h0
`define GRR_CH_ONE 4'h1

// Output code
`define GRR_CODE_W 10
`define GRR_CODE_RESET 10'h000
`define GRR_SWITCH_OPEN 10'h000
`define GRR_SWITCH_ONE 10'h001
// Largest change per refresh visit, in codes (2V over an 11V reference span)
`define GRR_STEP_CODE 10'h0ba

// Timing: system clock and internal refresh oscillator
`define GRR_MCLK_HZ 32'h0773_5940
`define GRR_OSC_HZ 32'h0000_5208
`define GRR_OSC_W 12
`define GRR_OSC_HALF (`GRR_MCLK_HZ / (32'h0000_0002 * `GRR_OSC_HZ))
`define GRR_OSC_RESET 12'h000
`define GRR_OSC_ONE 12'h001

`endif

// >>> grr_pkg.sv
// Types shared by the gamma reference serial and refresh control block
package grr_pkg;

  // One received programming word, most significant field first
  typedef struct packed {
    logic test_bit;
    logic clock_source_select;
    logic [3:0] channel_address_field;
    logic [9:0] output_code_field;
  } grr_word_t;

  // Refresh drive toward the converter and the hold switches
  typedef struct packed {
    logic [3:0] channel;
    logic [9:0] dac_code;
    logic [9:0] hold_switch;
  } grr_refresh_t;

endpackage

// >>> grr_serial_shift.sv
// Serial shift register on the serial clock, with daisy-chain output
`include "grr_defines.svh"

module grr_serial_shift (
  input wire logic serial_clk_i,
  input wire logic chip_enable_n_i,
  input wire logic serial_in_i,
  output grr_pkg::grr_word_t word_o,
  output logic word_full_o,
  output logic chain_out_o
);

  logic armed_r;
  logic [`GRR_CNT_W-1:0] count_r;
  logic [`GRR_CNT_W-1:0] count_nxt;
  logic [`GRR_WORD_MSB:0] shift_r;
  logic [`GRR_WORD_MSB:0] shift_nxt;
  logic chain_r;

  // Frame start marker, set while chip enable is high
  always_ff @(posedge serial_clk_i or posedge chip_enable_n_i) begin
    if (chip_enable_n_i) begin
      armed_r <= 1'b1;
    end else begin
      armed_r <= 1'b0;
    end
  end

  always_comb begin
    shift_nxt = shift_r;
    count_nxt = count_r;
    if (!chip_enable_n_i) begin
      shift_nxt = {shift_r[`GRR_WORD_MSB-1:0], serial_in_i};
      if (armed_r) begin
        count_nxt = `GRR_CNT_FIRST;
      end else if (count_r != `GRR_CNT_FULL) begin
        count_nxt = count_r + `GRR_CNT_ONE;
      end
    end
  end

  always_ff @(posedge serial_clk_i) begin
    shift_r <= shift_nxt;
    count_r <= count_nxt;
  end

  always_ff @(negedge serial_clk_i or posedge chip_enable_n_i) begin
    if (chip_enable_n_i) begin
      chain_r <= 1'b0;
    end else begin
      chain_r <= shift_r[`GRR_WORD_MSB];
    end
  end

  assign word_o = shift_r;
  assign word_full_o = (count_r == `GRR_CNT_FULL);
  assign chain_out_o = chain_r;

endmodule // grr_serial_shift

// >>> grr_refresh_top.sv
// Gamma reference control: serial word capture, clock source and channel refresh
// What this block does
// - Words are sixteen bits, MSB first
// - Bit fourteen selects external or internal clock
// - Bits thirteen to ten address the channel
// - Bits nine to zero are the code
// - Internal oscillator mode after power-up
// - Oscillator pin undriven after power-up
// - Internal mode drives ~21kHz clock out
// - Refresh starts falling edge, opens rising
// - Switches closed while low, open while high
// - One channel per cycle, ten-cycle round
// - Consecutive channels on consecutive cycles
// - Large changes approach in 2V steps
// - Shift on rising serial clock while enabled
// - Update on enable rise after full word
// - Chain output at sixteenth falling edge
`include "grr_defines.svh"

module grr_refresh_top (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic serial_clk_i,
  input wire logic chip_enable_n_i,
  input wire logic serial_in_pin_i,
  output logic serial_chain_out_o,
  input wire logic refresh_clock_pin_i,
  output logic refresh_clock_pin_o,
  output logic refresh_clock_pin_oe_o,
  output logic ext_mode_o,
  output logic word_accepted_o,
  output logic word_rejected_o,
  output grr_pkg::grr_refresh_t refresh_o
);

  grr_pkg::grr_word_t word;
  logic word_full;

  logic ce_s1_r;
  logic ce_s2_r;
  logic ce_s3_r;
  logic pin_s1_r;
  logic pin_s2_r;

  logic ext_mode_r;
  logic ext_mode_nxt;
  logic pin_drive_r;
  logic pin_drive_nxt;
  logic accepted_r;
  logic accepted_nxt;
  logic rejected_r;
  logic rejected_nxt;
  logic commit;

  logic [`GRR_OSC_W-1:0] osc_cnt_r;
  logic [`GRR_OSC_W-1:0] osc_cnt_nxt;
  logic osc_r;
  logic osc_nxt;

  logic ref_clk;
  logic ref_d_r;
  logic ref_fall;
  logic ref_rise;
  logic [`GRR_CH_W-1:0] chan_r;
  logic [`GRR_CH_W-1:0] chan_nxt;
  logic [`GRR_CH_W-1:0] chan_step;
  grr_pkg::grr_refresh_t refresh_r;
  grr_pkg::grr_refresh_t refresh_nxt;

  logic [`GRR_CODE_W-1:0] tgt_r [`GRR_NUM_CH];
  logic [`GRR_CODE_W-1:0] cur_r [`GRR_NUM_CH];
  logic [`GRR_CODE_W-1:0] step_val [`GRR_NUM_CH];

  grr_serial_shift u_shift (
    .serial_clk_i(serial_clk_i),
    .chip_enable_n_i(chip_enable_n_i),
    .serial_in_i(serial_in_pin_i),
    .word_o(word),
    .word_full_o(word_full),
    .chain_out_o(serial_chain_out_o)
  );

  // Pin synchronisers
  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ce_s1_r <= 1'b1;
      ce_s2_r <= 1'b1;
      ce_s3_r <= 1'b1;
      pin_s1_r <= 1'b0;
      pin_s2_r <= 1'b0;
    end else begin
      ce_s1_r <= chip_enable_n_i;
      ce_s2_r <= ce_s1_r;
      ce_s3_r <= ce_s2_r;
      pin_s1_r <= refresh_clock_pin_i;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign commit = ce_s2_r && !ce_s3_r && word_full;

  // Word decode and clock source selection
  always_comb begin
    ext_mode_nxt = ext_mode_r;
    pin_drive_nxt = pin_drive_r;
    accepted_nxt = 1'b0;
    rejected_nxt = 1'b0;
    if (ce_s2_r && !ce_s3_r) begin
      if (commit) begin
        ext_mode_nxt = word.clock_source_select;
        pin_drive_nxt = 1'b1;
        accepted_nxt = (word.channel_address_field <= `GRR_LAST_CH);
        rejected_nxt = (word.channel_address_field > `GRR_LAST_CH);
      end else begin
        rejected_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ext_mode_r <= 1'b0;
      pin_drive_r <= 1'b0;
      accepted_r <= 1'b0;
      rejected_r <= 1'b0;
    end else begin
      ext_mode_r <= ext_mode_nxt;
      pin_drive_r <= pin_drive_nxt;
      accepted_r <= accepted_nxt;
      rejected_r <= rejected_nxt;
    end
  end

  always_comb begin
    osc_cnt_nxt = osc_cnt_r + `GRR_OSC_ONE;
    osc_nxt = osc_r;
    if (osc_cnt_r == `GRR_OSC_W'(`GRR_OSC_HALF - 32'h0000_0001)) begin
      osc_cnt_nxt = `GRR_OSC_RESET;
      osc_nxt = !osc_r;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      osc_cnt_r <= `GRR_OSC_RESET;
      osc_r <= 1'b1;
    end else begin
      osc_cnt_r <= osc_cnt_nxt;
      osc_r <= osc_nxt;
    end
  end

  assign ref_clk = ext_mode_r ? pin_s2_r : osc_r;
  assign ref_fall = ref_d_r && !ref_clk;
  assign ref_rise = !ref_d_r && ref_clk;

  assign chan_step = (chan_r == `GRR_LAST_CH) ? `GRR_FIRST_CH : chan_r + `GRR_CH_ONE;

  // Per-channel target and present code
  genvar gi;
  generate
    for (gi = 0; gi < `GRR_NUM_CH; gi++) begin : g_ch
      logic [`GRR_CODE_W-1:0] tgt_nxt;
      logic [`GRR_CODE_W-1:0] cur_nxt;
      logic [`GRR_CODE_W-1:0] diff;
      logic up;

      always_comb begin
        up = tgt_r[gi] > cur_r[gi];
        diff = up ? tgt_r[gi] - cur_r[gi] : cur_r[gi] - tgt_r[gi];
        if (diff > `GRR_STEP_CODE) begin
          step_val[gi] = up ? cur_r[gi] + `GRR_STEP_CODE : cur_r[gi] - `GRR_STEP_CODE;
        end else begin
          step_val[gi] = tgt_r[gi];
        end
        tgt_nxt = tgt_r[gi];
        if (commit && word.channel_address_field == `GRR_CH_W'(gi)) begin
          tgt_nxt = word.output_code_field;
        end
        cur_nxt = cur_r[gi];
        if (ref_fall && chan_step == `GRR_CH_W'(gi)) begin
          cur_nxt = step_val[gi];
        end
      end

      always_ff @(posedge mclk_i) begin
        if (!reset_n_i) begin
          tgt_r[gi] <= `GRR_CODE_RESET;
          cur_r[gi] <= `GRR_CODE_RESET;
        end else begin
          tgt_r[gi] <= tgt_nxt;
          cur_r[gi] <= cur_nxt;
        end
      end
    end
  endgenerate

  // Refresh sequencer
  always_comb begin
    chan_nxt = chan_r;
    refresh_nxt = refresh_r;
    if (ref_fall) begin
      chan_nxt = chan_step;
      refresh_nxt.channel = chan_step;
      refresh_nxt.dac_code = step_val[chan_step];
      refresh_nxt.hold_switch = `GRR_SWITCH_ONE << chan_step;
    end else if (ref_rise) begin
      refresh_nxt.hold_switch = `GRR_SWITCH_OPEN;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      ref_d_r <= 1'b1;
      chan_r <= `GRR_LAST_CH;
      refresh_r.channel <= `GRR_LAST_CH;
      refresh_r.dac_code <= `GRR_CODE_RESET;
      refresh_r.hold_switch <= `GRR_SWITCH_OPEN;
    end else begin
      ref_d_r <= ref_clk;
      chan_r <= chan_nxt;
      refresh_r <= refresh_nxt;
    end
  end

  assign refresh_clock_pin_o = osc_r;
  assign refresh_clock_pin_oe_o = pin_drive_r && !ext_mode_r;
  assign ext_mode_o = ext_mode_r;
  assign word_accepted_o = accepted_r;
  assign word_rejected_o = rejected_r;
  assign refresh_o = refresh_r;

endmodule // grr_refresh_top

// >>> grr_refresh_props.sv
// Port checks for the gamma reference refresh control
module grr_refresh_props (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic refresh_clock_pin_i,
  input wire logic refresh_clock_pin_oe_o,
  input wire logic ext_mode_o,
  input wire logic word_accepted_o,
  input wire logic word_rejected_o,
  input wire grr_pkg::grr_refresh_t refresh_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);
  sequence sw_open;
    refresh_o.hold_switch == 10'h000;
  endsequence
  sequence word_done;
    word_accepted_o || word_rejected_o;
  endsequence
  pin_hiz_a:
    assert property ($rose(refresh_clock_pin_oe_o) |-> (word_accepted_o || word_rejected_o) && !ext_mode_o)
    else $error("pin driven early");
  mode_hold_a:
    assert property ($changed(ext_mode_o) |-> word_done) else $error("mode changed without word");
  ext_nodrive_a:
    assert property (ext_mode_o |-> !refresh_clock_pin_oe_o) else $error("pin driven in external mode");
  pulse_one_a:
    assert property (word_accepted_o |=> !word_accepted_o && !word_rejected_o) else $error("pulse too long");
  switch_hot_a:
    assert property (refresh_o.hold_switch != 10'h000 |-> refresh_o.hold_switch == (10'h001 << refresh_o.channel))
    else $error("wrong switch closed");
  chan_next_a:
    assert property ($changed(refresh_o.channel) |-> refresh_o.channel ==
      ($past(refresh_o.channel) == 4'h9 ? 4'h0 : $past(refresh_o.channel) + 4'h1)) else $error("channel order");
  close_fall_a:
    assert property ($rose(refresh_o.hold_switch != 10'h000) |-> $changed(refresh_o.channel))
    else $error("switch closed off visit");
  ext_open_a:
    assert property (ext_mode_o && $rose(refresh_clock_pin_i) |-> ##[1:6] sw_open) else $error("switch not opened");
endmodule // grr_refresh_props

bind grr_refresh_top grr_refresh_props grr_refresh_props_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
  .refresh_clock_pin_i(refresh_clock_pin_i), .refresh_clock_pin_oe_o(refresh_clock_pin_oe_o),
  .ext_mode_o(ext_mode_o), .word_accepted_o(word_accepted_o), .word_rejected_o(word_rejected_o),
  .refresh_o(refresh_o));

// >>> grr_host_model.sv
// Host model driving the three-wire serial port
module grr_host_model (
  output logic serial_clk_o,
  output logic chip_enable_n_o,
  output logic serial_in_o,
  input wire logic serial_chain_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serial_clk_o = 1'b0;
    chip_enable_n_o = 1'b1;
    serial_in_o = 1'b0;
  end
  // MSB-first frame, test bit zero, clock idle low
  // Extra leading bits are ones; chain output sampled before each rise
  task automatic send(input logic [15:0] w, input int n, output logic [15:0] seen);
    logic b;
    b = 1'b0;
    seen = 16'h0000;
    chip_enable_n_o <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      b = (i < 15) ? w[i] : ((i > 15) ? 1'b1 : 1'b0);
      serial_in_o <= b;
      #6;
      seen = {seen[14:0], serial_chain_i};
      serial_clk_o <= 1'b1;
      #6;
      serial_clk_o <= 1'b0;
    end
    #6;
    seen = {seen[14:0], serial_chain_i};
    chip_enable_n_o <= 1'b1;
    serial_in_o <= ~b;
  endtask
endmodule // grr_host_model

// >>> grr_refresh_top_test.sv
// Self-checking bench for the gamma reference refresh control
module grr_refresh_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, reset_n_i, ext_drv, pin_o, pin_oe, ext_mode, acc, rej, sclk, cs_n, serial_in_pin;
  grr_pkg::grr_refresh_t rf;
  logic chain;
  logic [15:0] chain_seen;
  int bad_count = 0;
  int tests_run = 0;
  int cnt = 0;
  wire pin_w = pin_oe ? pin_o : ext_drv;
  grr_host_model grr_host_model_i (.serial_clk_o(sclk), .chip_enable_n_o(cs_n), .serial_in_o(serial_in_pin),
    .serial_chain_i(chain));
  grr_refresh_top grr_refresh_top_i (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .serial_clk_i(sclk),
    .chip_enable_n_i(cs_n), .serial_in_pin_i(serial_in_pin), .serial_chain_out_o(chain), .refresh_clock_pin_i(pin_w),
    .refresh_clock_pin_o(pin_o), .refresh_clock_pin_oe_o(pin_oe), .ext_mode_o(ext_mode),
    .word_accepted_o(acc), .word_rejected_o(rej), .refresh_o(rf));
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  // external clock near 69kHz, even duty
  // no load change at rising edge
  always @(posedge mclk_i) begin
    cnt <= (cnt == 899) ? 0 : cnt + 1;
    if (cnt == 899) ext_drv <= ~ext_drv;
  end
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    if (bad_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic frame(input logic [15:0] w, input int n, input logic ok);
    int k;
    k = 0;
    grr_host_model_i.send(w, n, chain_seen);
    while (acc !== 1'b1 && rej !== 1'b1 && k < 20) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    cmp({14'h0, rej, acc}, {14'h0, ~ok, ok});
    if (k == 20) report_and_stop();
    repeat (6) @(posedge mclk_i);
    #1;
  endtask
  task automatic visit(input logic [3:0] ch, input logic [9:0] code);
    int k;
    k = 0;
    while (!(rf.channel === ch && rf.hold_switch !== 10'h000) && k < 25000) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    cmp({6'h0, rf.dac_code}, {6'h0, code});
    if (k == 25000) report_and_stop();
    while (rf.channel === ch && k < 30000) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
  endtask
  task automatic t_power_up();
    cmp({10'h0, ext_mode, pin_oe, rf.channel}, 16'h0009);
  endtask
  task automatic t_osc();
    int k;
    logic p;
    k = 0;
    p = pin_o;
    while (pin_o === p && k < 6000) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    if (k == 6000) begin
      bad_count++;
      report_and_stop();
    end
    p = pin_o;
    k = 0;
    while (pin_o === p && k < 6000) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    cmp(16'(k), 16'h0ba0);
    if (k == 6000) report_and_stop();
  endtask
  task automatic t_internal();
    frame(16'h0c50, 16, 1'b1);
    cmp({14'h0, ext_mode, pin_oe}, 16'h0001);
    t_osc();
  endtask
  task automatic t_partial();
    frame(16'h4000, 8, 1'b0);
    cmp({14'h0, ext_mode, pin_oe}, 16'h0001);
  endtask
  task automatic t_external();
    frame(16'h57ff, 17, 1'b1);
    cmp({14'h0, chain_seen[1:0]}, 16'h0002);
    cmp({14'h0, ext_mode, pin_oe}, 16'h0002);
    visit(4'h5, 10'h0ba);
    visit(4'h3, 10'h050);
    visit(4'h5, 10'h174);
  endtask
  task automatic t_bad_addr();
    frame(16'h3005, 16, 1'b0);
    cmp({14'h0, ext_mode, pin_oe}, 16'h0001);
  endtask
  initial begin
    reset_n_i = 1'b0;
    ext_drv = 1'b0;
    repeat (2) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    #1;
    t_power_up();
    t_internal();
    t_partial();
    t_external();
    t_bad_addr();
    report_and_stop();
  end
endmodule // grr_refresh_top_test
